/* File: common/dms_map.svh */
// Offsets, field positions, reset values, pin codes and timing counts of the DLL mode switch controller
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH
// Register byte offsets
`define DMS_OFS_CTRL 5'h00
`define DMS_OFS_MR0 5'h04
`define DMS_OFS_MR1 5'h08
`define DMS_OFS_MR2 5'h0C
`define DMS_OFS_STAT 5'h10
// Control fields
`define DMS_CTRL_START 0
`define DMS_CTRL_TO_OFF 1
`define DMS_CTRL_ZQ 2
// Status fields
`define DMS_STAT_BUSY 0
`define DMS_STAT_DONE 1
`define DMS_STAT_DLL_OFF 2
`define DMS_STAT_STATE_LSB 8
// Reset values
`define DMS_MR0_RST 14'h0000
`define DMS_MR1_RST 14'h0000
`define DMS_MR2_RST 14'h0000
// Mode register and ZQ command address bit positions
`define DMS_MR1_DLL_DIS_BIT 0
`define DMS_MR0_DLL_RST_BIT 8
`define DMS_ZQ_LONG_BIT 10
// Bank codes selecting a mode register
`define DMS_BA_MR0 3'h0
`define DMS_BA_MR1 3'h1
`define DMS_BA_MR2 3'h2
// Command codes {cs_n, ras_n, cas_n, we_n}
`define DMS_CMD_NOP 4'h7
`define DMS_CMD_MRS 4'h0
`define DMS_CMD_REF 4'h1
`define DMS_CMD_ZQ 4'h6
// Timing: clock period and printed figures
`define DMS_CLK_NS 20
`define DMS_T_MRD_NCK 4
`define DMS_T_MOD_NCK 12
`define DMS_T_CKSRE_NCK 5
`define DMS_T_CKSRX_NCK 5
`define DMS_T_XS_NS 170
`define DMS_T_DLLK_NCK 512
`define DMS_T_ZQOPER_NCK 256
// Nanoseconds to cycles, rounded up
`define DMS_NS2CK(ns) (((ns) + `DMS_CLK_NS - 1) / `DMS_CLK_NS)
`define DMS_T_XS_NCK `DMS_NS2CK(`DMS_T_XS_NS)
// AXI responses
`define DMS_RESP_OKAY 2'h0
`define DMS_RESP_SLVERR 2'h2
`endif

/* File: common/dms_pkg.sv */
// Types of the DLL mode switch controller
package dms_pkg;
   typedef logic [15:0] dms_cnt_t;
   typedef enum logic [4:0] {
      DMS_IDLE = 5'h00,
      DMS_MR1_DIS = 5'h01,
      DMS_W_MOD0 = 5'h03,
      DMS_SRE = 5'h02,
      DMS_W_SRE = 5'h06,
      DMS_FREQ = 5'h07,
      DMS_W_SRX = 5'h05,
      DMS_SRX = 5'h04,
      DMS_W_XS = 5'h0C,
      DMS_MR1_EN = 5'h0D,
      DMS_W_MRD1 = 5'h0F,
      DMS_DLL_RST = 5'h0E,
      DMS_W_MRD2 = 5'h0A,
      DMS_MR2_WR = 5'h0B,
      DMS_W_MRD3 = 5'h09,
      DMS_MR0_WR = 5'h08,
      DMS_W_MOD = 5'h18,
      DMS_ZQ = 5'h19,
      DMS_W_FIN = 5'h1B
   } dms_state_t;
endpackage

/* File: verilog/dms_wait_timer.sv */
// Down counter that marks the end of a programmed wait
`timescale 1ns/100ps
module dms_wait_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire dms_pkg::dms_cnt_t count,
   output logic done
);
   dms_pkg::dms_cnt_t cnt_q;
   dms_pkg::dms_cnt_t cnt_d;

   // Load wins over counting so a new wait never inherits the old one
   assign cnt_d = load ? count : ((cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q);
   assign done = (cnt_q == 16'h0000) && !load;

   // Counter register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

/* File: verilog/dms_ctrl.sv */
// DLL on/off switch sequencer driving the DRAM command pins, with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "dms_map.svh"

module dms_ctrl (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic dram_cke,
   output logic dram_cs_n,
   output logic dram_ras_n,
   output logic dram_cas_n,
   output logic dram_we_n,
   output logic [2:0] dram_ba,
   output logic [13:0] dram_addr,
   output logic dram_odt,
   output logic clk_change_req,
   input wire logic clk_stable
);
   // Wait lengths in cycles, each cut to the timer width
   localparam dms_pkg::dms_cnt_t CNT_MRD = 16'(`DMS_T_MRD_NCK);
   localparam dms_pkg::dms_cnt_t CNT_MOD = 16'(`DMS_T_MOD_NCK);
   localparam dms_pkg::dms_cnt_t CNT_CKSRE = 16'(`DMS_T_CKSRE_NCK);
   localparam dms_pkg::dms_cnt_t CNT_CKSRX = 16'(`DMS_T_CKSRX_NCK);
   localparam dms_pkg::dms_cnt_t CNT_XS = 16'(`DMS_T_XS_NCK);
   localparam dms_pkg::dms_cnt_t CNT_DLLK = 16'(`DMS_T_DLLK_NCK);
   localparam dms_pkg::dms_cnt_t CNT_ZQOPER = 16'(`DMS_T_ZQOPER_NCK);

   // Registers
   dms_pkg::dms_state_t state_q;
   dms_pkg::dms_state_t state_d;
   logic [13:0] mr0_q;
   logic [13:0] mr1_q;
   logic [13:0] mr2_q;
   logic to_off_q;
   logic zq_en_q;
   logic done_q;
   logic dll_off_q;
   logic stable_meta_q;
   logic stable_q;
   logic unstable_seen_q;
   logic aw_free_q;
   logic w_free_q;
   logic [4:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic cke_q;
   logic [3:0] cmd_q;
   logic [2:0] ba_q;
   logic [13:0] addr_q;
   logic clk_req_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Known register offset check, used by both read and write paths
   function automatic logic dms_mapped(input logic [4:0] a);
      dms_mapped = (a == `DMS_OFS_CTRL) || (a == `DMS_OFS_MR0) || (a == `DMS_OFS_MR1) ||
         (a == `DMS_OFS_MR2) || (a == `DMS_OFS_STAT);
   endfunction

   // Write decode: both halves held and no response pending
   wire wr_fire = !aw_free_q && !w_free_q && !bvalid_q;
   wire wr_ok = wr_fire && dms_mapped(aw_addr_q);
   wire wr_ctrl = wr_ok && (aw_addr_q == `DMS_OFS_CTRL) && w_strb_q[0];
   wire wr_mr0 = wr_ok && (aw_addr_q == `DMS_OFS_MR0);
   wire wr_mr1 = wr_ok && (aw_addr_q == `DMS_OFS_MR1);
   wire wr_mr2 = wr_ok && (aw_addr_q == `DMS_OFS_MR2);
   wire idle = (state_q == dms_pkg::DMS_IDLE);
   // A start while busy is ignored; the running sequence is never disturbed
   wire start = wr_ctrl && w_data_q[`DMS_CTRL_START] && idle;
   // The stable flag left over from the old rate is stale; a drop must be seen first
   wire freq_ok = stable_q && unstable_seen_q;
   wire rd_fire = s_axi_arvalid && arready_q;

   // Byte-lane merge for the 14-bit mode register images
   function automatic logic [13:0] dms_merge(input logic [13:0] old, input logic [31:0] d,
      input logic [3:0] s);
      logic [15:0] r;
      r = {2'h0, old};
      if (s[0]) begin
         r[7:0] = d[7:0];
      end
      if (s[1]) begin
         r[15:8] = d[15:8];
      end
      dms_merge = r[13:0];
   endfunction

   // Status word shows the sequencer's own progress
   wire [31:0] stat_word = {19'h0, state_q, 5'h0, dll_off_q, done_q, !idle};
   wire [31:0] ctrl_word = {29'h0, zq_en_q, to_off_q, 1'b0};
   wire [31:0] rd_word = (s_axi_araddr == `DMS_OFS_CTRL) ? ctrl_word :
      (s_axi_araddr == `DMS_OFS_MR0) ? {18'h0, mr0_q} :
      (s_axi_araddr == `DMS_OFS_MR1) ? {18'h0, mr1_q} :
      (s_axi_araddr == `DMS_OFS_MR2) ? {18'h0, mr2_q} :
      (s_axi_araddr == `DMS_OFS_STAT) ? stat_word : 32'h0000_0000;

   // Two wait timers: one for step spacing and the calibration run, one for the DLL lock
   logic step_load;
   dms_pkg::dms_cnt_t step_cnt;
   logic step_done;
   logic lock_load;
   dms_pkg::dms_cnt_t lock_cnt;
   logic lock_done;

   dms_wait_timer u_step (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(step_load),
      .count(step_cnt),
      .done(step_done)
   );

   dms_wait_timer u_lock (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(lock_load),
      .count(lock_cnt),
      .done(lock_done)
   );

   // Command state decode for the pin outputs
   wire is_mrs = (state_q == dms_pkg::DMS_MR1_DIS) || (state_q == dms_pkg::DMS_MR1_EN) ||
      (state_q == dms_pkg::DMS_DLL_RST) || (state_q == dms_pkg::DMS_MR2_WR) ||
      (state_q == dms_pkg::DMS_MR0_WR);
   wire in_sr = (state_q == dms_pkg::DMS_SRE) || (state_q == dms_pkg::DMS_W_SRE) ||
      (state_q == dms_pkg::DMS_FREQ) || (state_q == dms_pkg::DMS_W_SRX);
   wire [3:0] cmd_d = is_mrs ? `DMS_CMD_MRS :
      (state_q == dms_pkg::DMS_SRE) ? `DMS_CMD_REF :
      (state_q == dms_pkg::DMS_ZQ) ? `DMS_CMD_ZQ : `DMS_CMD_NOP;
   wire [2:0] ba_d = ((state_q == dms_pkg::DMS_MR1_DIS) || (state_q == dms_pkg::DMS_MR1_EN)) ? `DMS_BA_MR1 :
      (state_q == dms_pkg::DMS_MR2_WR) ? `DMS_BA_MR2 : `DMS_BA_MR0;
   wire [13:0] mr0_rst = mr0_q | (14'h0001 << `DMS_MR0_DLL_RST_BIT);
   wire [13:0] mr0_run = mr0_q & ~(14'h0001 << `DMS_MR0_DLL_RST_BIT);
   wire [13:0] mr1_dis = mr1_q | (14'h0001 << `DMS_MR1_DLL_DIS_BIT);
   wire [13:0] mr1_en = mr1_q & ~(14'h0001 << `DMS_MR1_DLL_DIS_BIT);
   wire [13:0] addr_d = (state_q == dms_pkg::DMS_MR1_DIS) ? mr1_dis :
      (state_q == dms_pkg::DMS_MR1_EN) ? mr1_en :
      (state_q == dms_pkg::DMS_DLL_RST) ? mr0_rst :
      (state_q == dms_pkg::DMS_MR2_WR) ? mr2_q :
      (state_q == dms_pkg::DMS_MR0_WR) ? mr0_run :
      (state_q == dms_pkg::DMS_ZQ) ? (14'h0001 << `DMS_ZQ_LONG_BIT) : 14'h0000;

   // Sequencer: command states load a wait, wait states move on when it ends
   always_comb begin
      state_d = state_q;
      step_load = 1'b0;
      step_cnt = CNT_MRD;
      lock_load = 1'b0;
      lock_cnt = CNT_DLLK;
      case (state_q)
         dms_pkg::DMS_IDLE: begin
            if (start) begin
               // Caller guarantees idle, banks precharged, termination off
               state_d = w_data_q[`DMS_CTRL_TO_OFF] ? dms_pkg::DMS_MR1_DIS : dms_pkg::DMS_SRE;
            end
         end
         dms_pkg::DMS_MR1_DIS: begin
            step_load = 1'b1;
            step_cnt = CNT_MOD;
            state_d = dms_pkg::DMS_W_MOD0;
         end
         dms_pkg::DMS_W_MOD0: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_SRE;
            end
         end
         dms_pkg::DMS_SRE: begin
            step_load = 1'b1;
            step_cnt = CNT_CKSRE;
            state_d = dms_pkg::DMS_W_SRE;
         end
         dms_pkg::DMS_W_SRE: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_FREQ;
            end
         end
         dms_pkg::DMS_FREQ: begin
            // Clock source reports the new rate settled
            if (freq_ok) begin
               step_load = 1'b1;
               step_cnt = CNT_CKSRX;
               state_d = dms_pkg::DMS_W_SRX;
            end
         end
         dms_pkg::DMS_W_SRX: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_SRX;
            end
         end
         dms_pkg::DMS_SRX: begin
            step_load = 1'b1;
            step_cnt = CNT_XS;
            state_d = dms_pkg::DMS_W_XS;
         end
         dms_pkg::DMS_W_XS: begin
            if (step_done) begin
               // DLL-off target skips straight to the register rewrite
               state_d = to_off_q ? dms_pkg::DMS_MR2_WR : dms_pkg::DMS_MR1_EN;
            end
         end
         dms_pkg::DMS_MR1_EN: begin
            step_load = 1'b1;
            state_d = dms_pkg::DMS_W_MRD1;
         end
         dms_pkg::DMS_W_MRD1: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_DLL_RST;
            end
         end
         dms_pkg::DMS_DLL_RST: begin
            step_load = 1'b1;
            lock_load = 1'b1;
            lock_cnt = CNT_DLLK;
            state_d = dms_pkg::DMS_W_MRD2;
         end
         dms_pkg::DMS_W_MRD2: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_MR2_WR;
            end
         end
         dms_pkg::DMS_MR2_WR: begin
            step_load = 1'b1;
            state_d = dms_pkg::DMS_W_MRD3;
         end
         dms_pkg::DMS_W_MRD3: begin
            if (step_done) begin
               state_d = dms_pkg::DMS_MR0_WR;
            end
         end
         dms_pkg::DMS_MR0_WR: begin
            step_load = 1'b1;
            step_cnt = CNT_MOD;
            state_d = dms_pkg::DMS_W_MOD;
         end
         dms_pkg::DMS_W_MOD: begin
            if (step_done) begin
               state_d = zq_en_q ? dms_pkg::DMS_ZQ : dms_pkg::DMS_W_FIN;
            end
         end
         dms_pkg::DMS_ZQ: begin
            // Calibration may overlap the lock wait; the longer one decides the end
            step_load = 1'b1;
            step_cnt = CNT_ZQOPER;
            state_d = dms_pkg::DMS_W_FIN;
         end
         dms_pkg::DMS_W_FIN: begin
            if (step_done && lock_done) begin
               state_d = dms_pkg::DMS_IDLE;
            end
         end
         default: begin
            state_d = dms_pkg::DMS_IDLE;
         end
      endcase
   end

   // Clock-stable pin passes two flops before use; a source that never drops it stalls the change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable_meta_q <= 1'b0;
         stable_q <= 1'b0;
         unstable_seen_q <= 1'b0;
      end else begin
         stable_meta_q <= clk_stable;
         stable_q <= stable_meta_q;
         unstable_seen_q <= (state_q == dms_pkg::DMS_FREQ) && (unstable_seen_q || !stable_q);
      end
   end

   // Sequencer state and completion flag; finishing wins over a clearing start
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= dms_pkg::DMS_IDLE;
         done_q <= 1'b0;
         dll_off_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if ((state_q == dms_pkg::DMS_W_FIN) && (state_d == dms_pkg::DMS_IDLE)) begin
            done_q <= 1'b1;
            dll_off_q <= to_off_q;
         end else if (start) begin
            done_q <= 1'b0;
         end
      end
   end

   // DRAM pins except the tied-low termination pin, all registered; cke low only inside self refresh
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cke_q <= 1'b1;
         cmd_q <= `DMS_CMD_NOP;
         ba_q <= 3'h0;
         addr_q <= 14'h0000;
         clk_req_q <= 1'b0;
      end else begin
         cke_q <= !in_sr;
         cmd_q <= cmd_d;
         ba_q <= ba_d;
         addr_q <= addr_d;
         clk_req_q <= ((state_q == dms_pkg::DMS_W_SRE) && step_done) || ((state_q == dms_pkg::DMS_FREQ) && !freq_ok);
      end
   end

   // Control and mode register images
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mr0_q <= `DMS_MR0_RST;
         mr1_q <= `DMS_MR1_RST;
         mr2_q <= `DMS_MR2_RST;
         to_off_q <= 1'b0;
         zq_en_q <= 1'b0;
      end else begin
         if (wr_mr0 && idle) begin
            mr0_q <= dms_merge(mr0_q, w_data_q, w_strb_q);
         end
         if (wr_mr1 && idle) begin
            mr1_q <= dms_merge(mr1_q, w_data_q, w_strb_q);
         end
         if (wr_mr2 && idle) begin
            mr2_q <= dms_merge(mr2_q, w_data_q, w_strb_q);
         end
         if (wr_ctrl && idle) begin
            to_off_q <= w_data_q[`DMS_CTRL_TO_OFF];
            zq_en_q <= w_data_q[`DMS_CTRL_ZQ];
         end
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_free_q <= 1'b1;
         w_free_q <= 1'b1;
         aw_addr_q <= 5'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `DMS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && aw_free_q) begin
            aw_free_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && w_free_q) begin
            w_free_q <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= dms_mapped(aw_addr_q) ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
         end
      end
   end

   // Read channel: one read at a time, data captured with the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `DMS_RESP_OKAY;
      end else begin
         if (rd_fire) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= dms_mapped(s_axi_araddr) ? `DMS_RESP_OKAY : `DMS_RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // Termination held low throughout, which satisfies both termination cases
   assign dram_odt = 1'b0;
   assign dram_cke = cke_q;
   assign dram_cs_n = cmd_q[3];
   assign dram_ras_n = cmd_q[2];
   assign dram_cas_n = cmd_q[1];
   assign dram_we_n = cmd_q[0];
   assign dram_ba = ba_q;
   assign dram_addr = addr_q;
   assign clk_change_req = clk_req_q;
   assign s_axi_awready = aw_free_q;
   assign s_axi_wready = w_free_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule

/* File: tb/dms_ctrl_monitor.sv */
// Checker of DRAM command timing and bus answers of the DLL switch controller
`timescale 1ns/100ps
`include "dms_map.svh"
module dms_ctrl_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic dram_cke,
   input wire logic dram_cs_n,
   input wire logic dram_ras_n,
   input wire logic dram_cas_n,
   input wire logic dram_we_n,
   input wire logic dram_odt,
   input wire logic clk_change_req,
   input wire logic clk_stable
);
   // Command decode of the active-low pins
   wire [3:0] cmd = {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n};
   wire mode_register_set = cmd == `DMS_CMD_MRS;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Entry and exit steps of self refresh
   sequence s_sr_entry;
      $fell(dram_cke) && cmd == `DMS_CMD_REF;
   endsequence
   sequence s_sr_exit;
      $rose(dram_cke);
   endsequence
   a_mrs_spacing: assert property (mode_register_set |=> !mode_register_set [*3]) else $error("mode sets too close");
   a_sre_command: assert property ($fell(dram_cke) |-> s_sr_entry) else $error("bad entry command");
   a_clock_hold: assert property (s_sr_entry |-> !clk_change_req [*5]) else $error("early clock change");
   a_change_in_sr: assert property (clk_change_req |-> !dram_cke) else $error("change outside refresh");
   a_stable_exit: assert property (s_sr_exit |-> $past(clk_stable, 5) && !$past(clk_change_req, 5))
      else $error("exit before clock stable");
   a_cke_holds: assert property (s_sr_exit |-> dram_cke [*8]) else $error("clock enable dropped");
   a_exit_wait: assert property (s_sr_exit |-> !mode_register_set [*8] ##1 !mode_register_set) else $error("mode set inside exit delay");
   a_mod_before_sre: assert property (mode_register_set |=> dram_cke [*8] ##1 dram_cke [*3])
      else $error("refresh entry inside update delay");
   a_odt_low: assert property (!dram_odt) else $error("termination pin high");
   a_nop_in_sr: assert property (!dram_cke && !$fell(dram_cke) |-> cmd == `DMS_CMD_NOP)
      else $error("command inside self refresh");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   c_exit: cover property (s_sr_exit);
endmodule
bind dms_ctrl dms_ctrl_monitor dms_ctrl_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dram_cke, .dram_cs_n, .dram_ras_n,
   .dram_cas_n, .dram_we_n, .dram_odt, .clk_change_req, .clk_stable);

/* File: tb/dms_dram_model.sv */
// Pin-level model of the DRAM mode registers, lock timer and command rules
`timescale 1ns/100ps
`include "dms_map.svh"
module dms_dram_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [2:0] ba,
   input wire logic [13:0] addr,
   input wire logic termination_control_pin,
   output logic dll_off,
   output logic locked,
   output logic zq_seen,
   output logic [13:0] mr0,
   output logic [7:0] faults
);
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   wire mode_register_set = cmd == `DMS_CMD_MRS;
   logic [15:0] gap_q, lock_q, sx_q;
   logic in_sr_q;
   // Broken rules seen at the pins; only counted, the bench judges the count
   wire bad = (mode_register_set && gap_q < 16'h0003) || termination_control_pin || (mode_register_set && !cke) || (mode_register_set && sx_q < `DMS_T_XS_NCK);
   // Mode register writes, lock timer and exit delay counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dll_off <= 1'b0;
         locked <= 1'b1;
         zq_seen <= 1'b0;
         mr0 <= 14'h0000;
         faults <= 8'h00;
         gap_q <= 16'h00FF;
         lock_q <= 16'h0000;
         sx_q <= 16'h0100;
         in_sr_q <= 1'b0;
      end else begin
         faults <= faults + {7'h00, bad};
         gap_q <= mode_register_set ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hFFFF};
         in_sr_q <= !cke;
         sx_q <= (in_sr_q && cke) ? 16'h0001 : sx_q + {15'h0000, sx_q < 16'h0100};
         if (mode_register_set && ba == `DMS_BA_MR1)
            dll_off <= addr[`DMS_MR1_DLL_DIS_BIT];
         if (mode_register_set && ba == `DMS_BA_MR0)
            mr0 <= addr;
         if (mode_register_set && ba == `DMS_BA_MR0 && addr[`DMS_MR0_DLL_RST_BIT]) begin
            lock_q <= 16'(`DMS_T_DLLK_NCK);
            locked <= 1'b0;
         end else if (lock_q != 16'h0000) begin
            lock_q <= lock_q - 16'h0001;
            locked <= lock_q == 16'h0001;
         end
         if (cmd == `DMS_CMD_ZQ && addr[`DMS_ZQ_LONG_BIT])
            zq_seen <= 1'b1;
      end
   end
endmodule

/* File: tb/dms_ctrl_bench.sv */
// Self-checking bench of the DLL switch controller with a DRAM pin model
`timescale 1ns/100ps
`include "dms_map.svh"
module dms_ctrl_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] aw_a = 5'h00, ar_a = 5'h00;
   logic [31:0] w_d = 32'h00000000;
   logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0, clk_stable = 1'b1;
   logic aw_r, w_r, b_v, ar_r, r_v, cke, cs_n, ras_n, cas_n, we_n, termination_control_pin, chg_req, dll_off, locked, zq_seen;
   logic [1:0] b_resp, r_resp, r;
   logic [31:0] r_d, v;
   logic [2:0] ba;
   logic [13:0] addr, mr0;
   logic [7:0] faults;
   logic [3:0] chg_cnt = 4'h0;
   int num_errors = 0;
   int checked = 0;
   dms_ctrl dms_ctrl_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
      .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
      .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
      .dram_cke(cke), .dram_cs_n(cs_n), .dram_ras_n(ras_n), .dram_cas_n(cas_n), .dram_we_n(we_n), .dram_ba(ba),
      .dram_addr(addr), .dram_odt(termination_control_pin), .clk_change_req(chg_req), .clk_stable(clk_stable));
   dms_dram_model dms_dram_model_i (.aclk(aclk), .aresetn(aresetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .termination_control_pin(termination_control_pin), .dll_off(dll_off), .locked(locked),
      .zq_seen(zq_seen), .mr0(mr0), .faults(faults));
   initial begin
      forever #10 aclk = ~aclk;
   end
   // Clock source: unstable on request, stable again after seven cycles
   always @(posedge aclk) begin
      if (chg_req) begin
         chg_cnt <= chg_cnt + {3'h0, chg_cnt != 4'hF};
         clk_stable <= chg_cnt > 4'h5;
      end else
         chg_cnt <= 4'h0;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   // Write with address and data offered together; bready held until the answer
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (aw_v && aw_r) begin
            ad = 1'b1;
            aw_v <= 1'b0;
         end
         if (w_v && w_r) begin
            wd = 1'b1;
            w_v <= 1'b0;
         end
      end
      do @(posedge aclk); while (!b_v);
      rs = b_resp;
      b_r <= 1'b0;
      // One idle edge so a following call never re-raises bready in the same step
      @(posedge aclk);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] rs);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      do @(posedge aclk); while (!ar_r);
      ar_v <= 1'b0;
      do @(posedge aclk); while (!r_v);
      d = r_d;
      rs = r_resp;
      r_r <= 1'b0;
      @(posedge aclk);
   endtask
   // Polls status until the sticky done bit shows; the watchdog bounds it
   task automatic wait_done;
      do rd(`DMS_OFS_STAT, v, r); while (v[`DMS_STAT_DONE] !== 1'b1);
   endtask
   task automatic t_regs;
      for (int i = 0; i < 5; i++) begin
         rd(5'(i * 4), v, r);
         chk("reset value", v, 32'h00000000);
      end
      wr(`DMS_OFS_MR2, 32'hFFFFFFFF, r);
      rd(`DMS_OFS_MR2, v, r);
      chk("image width", v, 32'h00003FFF);
      wr(`DMS_OFS_STAT, 32'h000000FF, r);
      chk("status write resp", 32'(r), 32'(`DMS_RESP_OKAY));
      rd(`DMS_OFS_STAT, v, r);
      chk("status read only", v, 32'h00000000);
      wr(5'h14, 32'h00000001, r);
      chk("unmapped write", 32'(r), 32'(`DMS_RESP_SLVERR));
      rd(5'h14, v, r);
      chk("unmapped read", {v[29:0], r}, 32'(`DMS_RESP_SLVERR));
   endtask
   task automatic t_to_off;
      wr(`DMS_OFS_MR0, 32'h00000120, r);
      wr(`DMS_OFS_MR1, 32'h00000004, r);
      wr(`DMS_OFS_CTRL, 32'h00000003, r);
      wr(`DMS_OFS_MR1, 32'h00000000, r);
      rd(`DMS_OFS_STAT, v, r);
      chk("busy", 32'(v[`DMS_STAT_BUSY]), 32'h00000001);
      wait_done;
      chk("status off", v, 32'h00000006);
      chk("loop disabled", 32'(dll_off), 32'h00000001);
      chk("reset bit clear", 32'(mr0), 32'h00000020);
      rd(`DMS_OFS_MR1, v, r);
      chk("busy write ignored", v, 32'h00000004);
      chk("pin faults", 32'(faults), 32'h00000000);
   endtask
   task automatic t_to_on;
      wr(`DMS_OFS_CTRL, 32'h00000005, r);
      wr(`DMS_OFS_CTRL, 32'h00000003, r);
      wait_done;
      chk("status on", v, 32'h00000002);
      chk("loop enabled", 32'(dll_off), 32'h00000000);
      chk("lock elapsed", 32'(locked), 32'h00000001);
      chk("calibration", 32'(zq_seen), 32'h00000001);
      chk("final mode", 32'(mr0), 32'h00000020);
      chk("pin faults", 32'(faults), 32'h00000000);
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Main sequence after five cycles of reset
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_to_off;
      t_to_on;
      end_of_test;
   end
   // Watchdog: both switches take a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      end_of_test;
   end
endmodule
